// >>> include/todt_pkg.sv
// constants and types shared by the turn-on delay timer files
package todt_pkg;
   // ************************************************************
   // register map and field layout
   // ************************************************************
   localparam logic [7:0]  CMD_TURN_ON_DELAY = 8'h60;
   localparam logic [15:0] RST_TURN_ON_DELAY = 16'hCA80;
   localparam int          EXP_MSB           = 15;
   localparam int          EXP_LSB           = 11;
   localparam int          MAN_MSB           = 10;
   localparam int          MAN_LSB           = 0;
   localparam logic [7:0]  PAGE_ALL          = 8'hFF;
   localparam int          NUM_PAGES         = 2;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int NS_PER_MS      = 1000000;
   localparam int MIN_DELAY_MS   = 3;
   localparam int MAX_DELAY_MS   = 5000;
   localparam int CYC_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;

   // ************************************************************
   // delay channel states
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_COUNT = 2'h1,
      ST_RAMP  = 2'h3
   } todt_state_t;
endpackage

// >>> rtl/todt_delay_chan.sv
// one output's delay counter: waits the loaded cycle count after enable
`timescale 1ns/100ps
module todt_delay_chan (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        enable,
   input  wire logic [31:0] load_cycles,
   output logic             ramp_go,
   output logic             busy
);
   typedef struct packed {
      todt_pkg::todt_state_t state;
      logic [31:0]           cnt;
      logic                  ramp_go;
      logic                  busy;
   } todt_chan_t;

   todt_chan_t r;
   todt_chan_t next_r;

   always_comb begin
      next_r = r;
      case (r.state)
         todt_pkg::ST_IDLE: begin
            // the count is captured here, so later writes affect the next enable only
            if (enable) begin
               next_r.state = todt_pkg::ST_COUNT;
               next_r.cnt   = load_cycles - 32'h1;
               next_r.busy  = 1'b1;
            end
         end
         todt_pkg::ST_COUNT: begin
            if (!enable) begin
               next_r.state = todt_pkg::ST_IDLE;
               next_r.busy  = 1'b0;
            end else if (r.cnt == 32'h0) begin
               next_r.state   = todt_pkg::ST_RAMP;
               next_r.ramp_go = 1'b1;
               next_r.busy    = 1'b0;
            end else begin
               next_r.cnt = r.cnt - 32'h1;
            end
         end
         todt_pkg::ST_RAMP: begin
            if (!enable) begin
               next_r.state   = todt_pkg::ST_IDLE;
               next_r.ramp_go = 1'b0;
            end
         end
         default: begin
            next_r.state   = todt_pkg::ST_IDLE;
            next_r.ramp_go = 1'b0;
            next_r.busy    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{todt_pkg::ST_IDLE, 32'h0, 1'b0, 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign ramp_go = r.ramp_go;
   assign busy    = r.busy;
endmodule

// >>> rtl/todt_turn_on_delay_timer.sv
// per-output turn-on delay timer with its paged delay setting
// Notes on behaviour
// - once an output is enabled, wait the programmed delay, then start its ramp.
// - setting is a 16-bit Linear-11 word; delay in ms is mantissa times two^exponent.
// - each output page has its own setting; selected page picks the accessed one.
// - after reset every page's setting holds 0xCA80, which means 5 ms.
// - range is 0 to 5 s; the timer covers 5 s, longer values clamp.
// - decoded delays below 3 ms are stretched to exactly 3 ms.
`timescale 1ns/100ps
module todt_turn_on_delay_timer #(
   parameter int CYC_PER_MS = todt_pkg::CYC_PER_MS_DEF
) (
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   input  wire logic [7:0]  PAGE,
   input  wire logic [7:0]  CMD_CODE,
   input  wire logic        CMD_WR,
   input  wire logic        CMD_RD,
   input  wire logic [15:0] WR_DATA,
   input  wire logic [1:0]  OUTPUT_ENABLE,
   output logic      [15:0] RD_DATA,
   output logic             CMD_ACK,
   output logic             CMD_NAK,
   output logic      [1:0]  RAMP_START,
   output logic      [1:0]  DELAY_BUSY
);
   localparam logic [63:0] MIN_CYC =
      64'(todt_pkg::MIN_DELAY_MS) * 64'(CYC_PER_MS);
   localparam logic [63:0] MAX_CYC =
      64'(todt_pkg::MAX_DELAY_MS) * 64'(CYC_PER_MS);

   typedef struct packed {
      logic [todt_pkg::NUM_PAGES-1:0][15:0] delay_word;
      logic [15:0]                          rd_data;
      logic                                 ack;
      logic                                 nak;
   } todt_regs_t;

   todt_regs_t r;
   todt_regs_t next_r;

   // ************************************************************
   // linear-11 decode into clock cycles
   // ************************************************************
   // fractions of a cycle are dropped; the loss is always under one clock cycle
   function automatic logic [31:0] delay_cycles(input logic [15:0] w);
      logic signed [4:0] expo;
      logic [63:0]       prod;
      expo = w[todt_pkg::EXP_MSB:todt_pkg::EXP_LSB];
      if (w[todt_pkg::MAN_MSB]) begin
         prod = 64'h0; // negative delays decode to zero, which the clamp raises to 3 ms
      end else begin
         prod = 64'(w[todt_pkg::MAN_MSB-1:todt_pkg::MAN_LSB]) * 64'(CYC_PER_MS);
      end
      if (expo[4]) begin
         prod = prod >> 5'(-expo);
      end else begin
         prod = prod << expo[3:0];
      end
      if (prod < MIN_CYC) begin
         prod = MIN_CYC;
      end else if (prod > MAX_CYC) begin
         prod = MAX_CYC;
      end
      return prod[31:0];
   endfunction

   // ************************************************************
   // command access to the paged setting
   // ************************************************************
   logic hit;
   logic page_ok;
   logic page_one;

   always_comb begin
      next_r   = r;
      hit      = (CMD_CODE == todt_pkg::CMD_TURN_ON_DELAY);
      page_one = (PAGE == 8'h01);
      page_ok  = (PAGE == 8'h00) || page_one || (PAGE == todt_pkg::PAGE_ALL);
      next_r.ack = 1'b0;
      next_r.nak = 1'b0;
      if (CMD_WR) begin
         if (hit && page_ok) begin
            next_r.ack = 1'b1;
            for (int i = 0; i < todt_pkg::NUM_PAGES; i++) begin
               // page all reaches every output at once
               if (PAGE == todt_pkg::PAGE_ALL || page_one == (i == 1)) begin
                  next_r.delay_word[i] = WR_DATA;
               end
            end
         end else begin
            next_r.nak = 1'b1;
         end
      end else if (CMD_RD) begin
         if (hit && page_ok) begin
            next_r.ack     = 1'b1;
            next_r.rd_data = r.delay_word[page_one];
         end else begin
            next_r.nak     = 1'b1;
            next_r.rd_data = 16'h0000;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         r.delay_word <= {todt_pkg::NUM_PAGES{todt_pkg::RST_TURN_ON_DELAY}};
         r.rd_data    <= 16'h0000;
         r.ack        <= 1'b0;
         r.nak        <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign RD_DATA = r.rd_data;
   assign CMD_ACK = r.ack;
   assign CMD_NAK = r.nak;

   // ************************************************************
   // one delay channel per output
   // ************************************************************
   for (genvar g = 0; g < todt_pkg::NUM_PAGES; g++) begin : g_chan
      todt_delay_chan u_chan (
         .clk         (MCLK),
         .rst_n       (RSTN),
         .enable      (OUTPUT_ENABLE[g]),
         .load_cycles (delay_cycles(r.delay_word[g])),
         .ramp_go     (RAMP_START[g]),
         .busy        (DELAY_BUSY[g])
      );
   end
endmodule

// >>> tb/todt_checker.sv
// port checker for the turn-on delay timer
`timescale 1ns/100ps
module todt_checker #(parameter int CYC_PER_MS = 10) (
   input wire logic        MCLK,
   input wire logic        RSTN,
   input wire logic [7:0]  PAGE,
   input wire logic [7:0]  CMD_CODE,
   input wire logic        CMD_WR,
   input wire logic        CMD_RD,
   input wire logic [15:0] WR_DATA,
   input wire logic [1:0]  OUTPUT_ENABLE,
   input wire logic [15:0] RD_DATA,
   input wire logic        CMD_ACK,
   input wire logic        CMD_NAK,
   input wire logic [1:0]  RAMP_START,
   input wire logic [1:0]  DELAY_BUSY
);
   // slack of two cycles absorbs where the busy count is sampled
   localparam int MINC = 3 * CYC_PER_MS - 2;
   logic [31:0] run;
   wire logic   req = CMD_WR | CMD_RD;
   always_ff @(posedge MCLK or negedge RSTN)
      if (!RSTN) run <= '0;
      else run <= DELAY_BUSY[0] ? run + 32'h1 : '0;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   property p_ack; req && CMD_CODE == 8'h60 && PAGE == 8'h00 |=> CMD_ACK; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_nak; req && CMD_CODE != 8'h60 |=> CMD_NAK && !CMD_ACK; endproperty
   a_nak: assert property (p_nak) else $error("no nak");
   property p_go; OUTPUT_ENABLE[0] && !DELAY_BUSY[0] && !RAMP_START[0] |=> DELAY_BUSY[0]; endproperty
   a_go: assert property (p_go) else $error("no count");
   property p_min; $rose(RAMP_START[0]) |-> run >= MINC; endproperty
   a_min: assert property (p_min) else $error("delay short");
   property p_max; run <= 5000 * CYC_PER_MS; endproperty
   a_max: assert property (p_max) else $error("delay long");
   property p_off; !OUTPUT_ENABLE[0] |=> !DELAY_BUSY[0] && !RAMP_START[0]; endproperty
   a_off: assert property (p_off) else $error("no abort");
   property p_keep; !CMD_RD |=> $stable(RD_DATA); endproperty
   a_keep: assert property (p_keep) else $error("read word moved");
   c_ramp: cover property ($rose(RAMP_START[0]));
   c_nak: cover property (CMD_NAK);
   c_abort: cover property ($fell(DELAY_BUSY[0]) && !RAMP_START[0]);
endmodule
bind todt_turn_on_delay_timer todt_checker #(.CYC_PER_MS(CYC_PER_MS)) i_chk (.*);

// >>> tb/todt_host.sv
// host model issuing command-port accesses
`timescale 1ns/100ps
module todt_host (
   input  wire logic        clk,
   input  wire logic        ack,
   input  wire logic        nak,
   input  wire logic [15:0] rd_data,
   output logic      [7:0]  page,
   output logic      [7:0]  code,
   output logic             wr,
   output logic             rd,
   output logic      [15:0] wdata
);
   initial {page, code, wr, rd, wdata} = '0;
   // one strobe per whole word; released data is inverted, never left as a stale copy
   task automatic access(input logic is_rd, input logic [7:0] pg, input logic [7:0] cd,
                         input logic [15:0] d, output logic [17:0] resp);
      @(posedge clk);
      {page, code, wr, rd, wdata} <= {pg, cd, !is_rd, is_rd, d};
      @(posedge clk);
      {wr, rd, wdata} <= {2'b00, ~d};
      #1 resp = {ack, nak, rd_data};
   endtask
endmodule

// >>> tb/todt_turn_on_delay_timer_tb_top.sv
// self-checking bench for the turn-on delay timer
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) fail_line(a, b); end
module todt_turn_on_delay_timer_tb_top;
   logic        mclk, rstn, ack, nak, wr, rd;
   logic [7:0]  page, code;
   logic [15:0] wdata, rdata;
   logic [1:0]  en, ramp, busy;
   logic [17:0] r;
   int          n_fail, comparisons;
   todt_host i_host (.clk(mclk), .ack(ack), .nak(nak), .rd_data(rdata), .page(page),
                     .code(code), .wr(wr), .rd(rd), .wdata(wdata));
   todt_turn_on_delay_timer #(.CYC_PER_MS(10)) i_dut (.MCLK(mclk), .RSTN(rstn), .PAGE(page),
      .CMD_CODE(code), .CMD_WR(wr), .CMD_RD(rd), .WR_DATA(wdata), .OUTPUT_ENABLE(en),
      .RD_DATA(rdata), .CMD_ACK(ack), .CMD_NAK(nak), .RAMP_START(ramp), .DELAY_BUSY(busy));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic fail_line(input logic [31:0] g, input logic [31:0] e);
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // edges are counted from the drive edge, so the ramp shows at count delay + 1
   task automatic run(input int ch, input int exp_cyc);
      int n;
      n = 0;
      @(posedge mclk);
      en[ch] <= 1'b1;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (ramp[ch] !== 1'b1 && n < 60000);
      `CHK(n, exp_cyc + 1)
      `CHK(busy[ch], 1'b0)
      @(posedge mclk);
      en[ch] <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic t_reset_values;
      for (int p = 0; p < 2; p++) begin
         i_host.access(1'b1, 8'(p), 8'h60, 16'h0000, r);
         `CHK(r, {2'b10, 16'hCA80})
      end
      run(0, 50);
      run(1, 50);
   endtask
   task automatic t_encodings;
      // host keeps to 0..5 s: zero and exactly 5 s bound the span, 2 ms shows the clamp
      logic [15:0] w [6] = '{16'h0002, 16'h0000, 16'h0007, 16'h0803, 16'hF80E, 16'h1A71};
      int          c [6] = '{30, 30, 70, 60, 70, 50000};
      for (int i = 0; i < 6; i++) begin
         i_host.access(1'b0, 8'h00, 8'h60, w[i], r);
         i_host.access(1'b1, 8'h00, 8'h60, 16'h0000, r);
         `CHK(r, {2'b10, w[i]})
         run(0, c[i]);
      end
      i_host.access(1'b1, 8'h01, 8'h60, 16'h0000, r);
      `CHK(r[15:0], 16'hCA80)
   endtask
   task automatic t_refuse_abort;
      i_host.access(1'b0, 8'h00, 8'h61, 16'h0003, r);
      `CHK(r[17:16], 2'b01)
      i_host.access(1'b0, 8'h02, 8'h60, 16'h0003, r);
      `CHK(r[17:16], 2'b01)
      i_host.access(1'b0, 8'hFF, 8'h60, 16'h0004, r);
      i_host.access(1'b1, 8'h01, 8'h60, 16'h0000, r);
      `CHK(r, {2'b10, 16'h0004})
      @(posedge mclk);
      en[1] <= 1'b1;
      repeat (20) @(posedge mclk);
      en[1] <= 1'b0;
      repeat (40) @(posedge mclk);
      #1 `CHK({ramp[1], busy[1]}, 2'b00)
   endtask
   initial begin
      rstn = 1'b0;
      en = 2'b00;
      n_fail = 0;
      comparisons = 0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      t_reset_values();
      t_encodings();
      t_refuse_abort();
      conclude();
   end
   // the longest delay is 50000 cycles; the limit of 100000 cycles is twice that
   initial begin
      #1000000;
      n_fail++;
      conclude();
   end
endmodule
